// ---- hw/pmr_defs.svh ----
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// ----------------------------------------------------------------
// Mode entry field positions
// ----------------------------------------------------------------
`define PMR_MODE_W 14
`define PMR_KIND_HI 9
`define PMR_KIND_LO 8
`define PMR_BASE_HI 7
`define PMR_BASE_LO 3
`define PMR_BUF_BIT 0
`define PMR_DEPTH_HI 11
`define PMR_DEPTH_LO 10

// ----------------------------------------------------------------
// Encodings and widths
// ----------------------------------------------------------------
`define PMR_KIND_INDEX 2'h0
`define PMR_DEPTH_4 2'h0
`define PMR_DEPTH_8 2'h1
`define PMR_DEPTH_12 2'h2
`define PMR_DEPTH_24 2'h3
`define PMR_PIX_W 24
`define PMR_ADDR_W 13
`define PMR_HALF 12
`define PMR_NIB 4
`define PMR_BYTE 8
`define PMR_ZERO_NIB 4'h0
`define PMR_ZERO_WORD 24'h00_0000
`define PMR_ALPHA8_LO 12
`define PMR_ALPHA4_LO 8
`define PMR_LATENCY 2

`endif

// ---- hw/pmr_pkg.sv ----
`default_nettype none
`include "pmr_defs.svh"

package pmr_pkg;

  // Pixel depth selections
  typedef enum logic [1:0] {
    PMR_D4 = `PMR_DEPTH_4,
    PMR_D8 = `PMR_DEPTH_8,
    PMR_D12 = `PMR_DEPTH_12,
    PMR_D24 = `PMR_DEPTH_24
  } pmr_depth_t;

  // Decoded mode entry fields
  typedef struct packed {
    logic alpha_en;
    pmr_depth_t depth;
    logic [1:0] kind;
    logic [4:0] palette_base_bits;
    logic buf_sel;
  } pmr_mode_t;

  // Pixel word with its mode
  typedef struct packed {
    logic valid;
    pmr_mode_t mode;
    logic [23:0] pix;
  } pmr_beat_t;

  // Alpha bits and their presence
  typedef struct packed {
    logic present;
    logic [7:0] bits;
  } pmr_alpha_t;

endpackage
`default_nettype wire

// ---- hw/pmr_index_fmt.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmr_defs.svh"

// ----------------------------------------------------------------
// Index address builder, purely combinational
// ----------------------------------------------------------------
module pmr_index_fmt (
  // Decoded mode and effective buffer
  input wire pmr_pkg::pmr_mode_t mode,
  input wire logic buf_one,
  // Raw pixel word
  input wire logic [23:0] pix,
  // Lookup address, upper bits zero
  output logic [23:0] addr
);

  // Address per depth
  always_comb begin
    addr = `PMR_ZERO_WORD;
    unique case (mode.depth)
      pmr_pkg::PMR_D4: begin
        // Base, zero nibble, selected nibble
        addr[12:8] = mode.palette_base_bits;
        addr[7:4] = `PMR_ZERO_NIB;
        addr[3:0] = buf_one ? pix[7:4] : pix[3:0];
      end
      pmr_pkg::PMR_D8: begin
        addr[12:8] = mode.palette_base_bits;
        addr[7:0] = pix[7:0];
      end
      pmr_pkg::PMR_D12: begin
        addr[12] = mode.palette_base_bits[4];
        addr[11:0] = buf_one ? pix[23:12] : pix[11:0];
      end
      pmr_pkg::PMR_D24: begin
        // Illegal for index: fall back to 8-bit form
        addr[12:8] = mode.palette_base_bits;
        addr[7:0] = pix[7:0];
      end
    endcase
  end

endmodule
`default_nettype wire

// ---- hw/pmr_rgb_fmt.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmr_defs.svh"

// ----------------------------------------------------------------
// RGB de-interleave and bit replication
// ----------------------------------------------------------------
module pmr_rgb_fmt (
  // Depth and effective buffer
  input wire pmr_pkg::pmr_depth_t depth,
  input wire logic buf_one,
  // Raw pixel word
  input wire logic [23:0] pix,
  // Blue 23..16, green 15..8, red 7..0
  output logic [23:0] rgb
);

  // Buffer one shifts the 8- and 12-bit sources up by a half word; 4-bit sources move up four bits
  logic [11:0] half;
  assign half = buf_one ? pix[23:12] : pix[11:0];

  // Channel k (0 green, 1 red, 2 blue) msb-first source lists
  logic [7:0] ch24 [3];
  logic [7:0] ch12 [3];
  logic [7:0] ch8 [3];
  logic [7:0] ch4 [3];

  genvar k, b;
  generate
    for (k = 0; k < 3; k++) begin : g_ch
      for (b = 0; b < 8; b++) begin : g_bit
        // Output bit 7-b takes source k + 3*b
        assign ch24[k][7-b] = pix[k + 3*b];
        // Four sources repeated twice
        assign ch12[k][7-b] = half[k + 3*(b % 4)];
      end
    end
    for (b = 0; b < 8; b++) begin : g_small
      // Green and red: three sources, cycled
      assign ch8[0][7-b] = half[3*(b % 3)];
      assign ch8[1][7-b] = half[1 + 3*(b % 3)];
      // Blue: two sources alternated
      assign ch8[2][7-b] = half[2 + 3*(b % 2)];
      // Four-bit: green alternates 0/3, others one bit
      assign ch4[0][7-b] = (b % 2 == 0) ? pix[buf_one ? 4 : 0]
                                          : pix[buf_one ? 7 : 3];
      assign ch4[1][7-b] = pix[buf_one ? 5 : 1];
      assign ch4[2][7-b] = pix[buf_one ? 6 : 2];
    end
  endgenerate

  // Depth select, channels replicated rather than zero padded
  always_comb begin
    rgb = `PMR_ZERO_WORD;
    unique case (depth)
      pmr_pkg::PMR_D4: rgb = {ch4[2], ch4[0], ch4[1]};
      pmr_pkg::PMR_D8: rgb = {ch8[2], ch8[0], ch8[1]};
      pmr_pkg::PMR_D12: rgb = {ch12[2], ch12[0], ch12[1]};
      pmr_pkg::PMR_D24: rgb = {ch24[2], ch24[0], ch24[1]};
    endcase
  end

endmodule
`default_nettype wire

// ---- hw/pmr_top.sv ----
// Behaviour
// - Low half is buffer zero, high buffer one; 4-bit uses low and high nibble
// - Kind 00 means index, else RGB
// - Depth selects 4/8/12/24; 24 RGB only
// - Buffer bit honoured only in double modes
// - Alpha merged with returning lookup RGB
// - Alpha valid RGB depth 01 or 10
// - Index address on bits 12..0
// - Four-bit index: base, zeros, nibble
// - Eight-bit index: base then pixel byte
// - Twelve-bit index: top base bit, half
// - RGB drives blue, green, red bytes
// - All output goes through the lookup
// - Short channels repeat bits, never zero
// - 24-bit RGB interleave by threes
// - Eight-bit RGB repeat pattern per buffer
// - Twelve-bit RGB repeat pattern per buffer
// - Four-bit RGB repeat pattern per buffer
// - Accept 4448 and 3324 alpha layouts
// - Accept popup and aux bits per pixel
// - Depth codes 00,01,10,11 for 4..24
// - Palette base from mode bits 7..3
// - Buffer choice from mode bit 0
// - Kind field from mode bits 9..8
`timescale 1ns/1ps
`default_nettype none
`include "pmr_defs.svh"

module pmr_top #(
  parameter int PIX_W = `PMR_PIX_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Pixel word and mode entry from the reorganizer
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_in,
  input wire logic [`PMR_MODE_W-1:0] mode_in,
  input wire logic alpha_en,
  // Popup and aux bits carried alongside
  input wire logic [1:0] popup_in,
  input wire logic [7:0] aux_in,
  // RGB returning from the lookup chip
  input wire logic lut_valid,
  input wire logic [23:0] lut_rgb,
  // Word towards the lookup chip
  output logic out_valid_r,
  output logic out_is_rgb_r,
  output logic [PIX_W-1:0] pix_out_r,
  output logic [1:0] popup_out_r,
  output logic [7:0] aux_out_r,
  // Combined word towards the video option board
  output logic video_valid_r,
  output logic [31:0] video_word_r
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  pmr_pkg::pmr_mode_t mode;
  logic is_index;
  logic dbl_mode;
  logic buf_one;
  logic alpha_ok;

  // Field extraction from the mode entry
  always_comb begin
    mode.kind = mode_in[`PMR_KIND_HI:`PMR_KIND_LO];
    mode.palette_base_bits = mode_in[`PMR_BASE_HI:`PMR_BASE_LO];
    mode.buf_sel = mode_in[`PMR_BUF_BIT];
    mode.depth = pmr_pkg::pmr_depth_t'(
      mode_in[`PMR_DEPTH_HI:`PMR_DEPTH_LO]);
    mode.alpha_en = alpha_en;
  end

  // Kind 00 is index, any other map code is RGB
  assign is_index = (mode.kind == `PMR_KIND_INDEX);

  // Alpha only counts for RGB at depth 8 or 12
  assign alpha_ok = mode.alpha_en && !is_index &&
    (mode.depth == pmr_pkg::PMR_D8 ||
     mode.depth == pmr_pkg::PMR_D12);

  // Double-buffered layouts: 4 bit, 12 bit without alpha, or 8-bit RGB with alpha
  always_comb begin
    dbl_mode = 1'b0;
    unique case (mode.depth)
      pmr_pkg::PMR_D4: dbl_mode = 1'b1;
      pmr_pkg::PMR_D8: dbl_mode = alpha_ok;
      pmr_pkg::PMR_D12: dbl_mode = !alpha_ok; // 4448 is single
      pmr_pkg::PMR_D24: dbl_mode = 1'b0;
    endcase
  end

  // Buffer bit forced to zero outside double modes
  assign buf_one = dbl_mode & mode.buf_sel;

  // ----------------------------------------------------------------
  // Formatters
  // ----------------------------------------------------------------
  logic [23:0] idx_addr;
  logic [23:0] rgb_word;

  // Index address path
  pmr_index_fmt u_index (
    .mode(mode),
    .buf_one(buf_one),
    .pix(pix_in),
    .addr(idx_addr)
  );

  // RGB path; 3324 and 4448 RGB parts sit where 332/444 do
  pmr_rgb_fmt u_rgb (
    .depth(mode.depth),
    .buf_one(buf_one),
    .pix(pix_in),
    .rgb(rgb_word)
  );

  // ----------------------------------------------------------------
  // Alpha extraction
  // ----------------------------------------------------------------
  pmr_pkg::pmr_alpha_t alpha_now;

  // Four alpha bits atop each 332 half, or eight atop 444
  // Alpha is stored lsb at the high pixel bit, so it is reversed here;
  // the four-bit form carries the upper alpha bits, lower ones zero
  always_comb begin
    alpha_now.present = alpha_ok;
    alpha_now.bits = 8'h00;
    if (alpha_ok && mode.depth == pmr_pkg::PMR_D12) begin
      // Pixel bit 12 is the alpha msb
      for (int i = 0; i < `PMR_BYTE; i++) begin
        alpha_now.bits[i] = pix_in[`PMR_ALPHA8_LO + `PMR_BYTE - 1 - i];
      end
    end else if (alpha_ok) begin
      // Pick the half, then its top nibble, low bit as msb
      for (int i = 0; i < `PMR_NIB; i++) begin
        alpha_now.bits[`PMR_BYTE - 1 - i] = buf_one ?
          pix_in[`PMR_HALF + `PMR_ALPHA4_LO + i] :
          pix_in[`PMR_ALPHA4_LO + i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage: one word per clock, same depth for all modes
  // ----------------------------------------------------------------
  // Both formats go to the lookup; no path skips it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_r <= 1'b0;
      out_is_rgb_r <= 1'b0;
      pix_out_r <= `PMR_ZERO_WORD;
    end else begin
      out_valid_r <= pix_valid;
      out_is_rgb_r <= !is_index;
      // Index: upper bits held zero for determinism
      pix_out_r <= is_index ? idx_addr : rgb_word;
    end
  end

  // Popup and aux ride along unchanged, same latency
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      popup_out_r <= 2'h0;
      aux_out_r <= 8'h00;
    end else begin
      popup_out_r <= popup_in;
      aux_out_r <= aux_in;
    end
  end

  // ----------------------------------------------------------------
  // Alpha delay line to meet the lookup's returning RGB
  // ----------------------------------------------------------------
  // Lookup round trip assumed fixed; depth is a parameter-like define
  pmr_pkg::pmr_alpha_t alpha_pipe_r [`PMR_LATENCY];

  // Shift alpha along so it pairs with the returning colour
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `PMR_LATENCY; i++) begin
        alpha_pipe_r[i] <= '0;
      end
    end else begin
      alpha_pipe_r[0] <= alpha_now;
      for (int i = 1; i < `PMR_LATENCY; i++) begin
        alpha_pipe_r[i] <= alpha_pipe_r[i-1];
      end
    end
  end

  // Merge alpha above lookup RGB for the video board
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      video_valid_r <= 1'b0;
      video_word_r <= 32'h0000_0000;
    end else begin
      // Only RGB pixels with alpha at depth 8 or 12 are forwarded
      video_valid_r <= lut_valid & alpha_pipe_r[`PMR_LATENCY-1].present;
      video_word_r <= {alpha_pipe_r[`PMR_LATENCY-1].bits, lut_rgb};
    end
  end

endmodule
`default_nettype wire

// ---- test/pmr_top_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmr_defs.svh"

// ----------------------------------------------------------------
// Port checker for the pixel reformatter
// ----------------------------------------------------------------
module pmr_top_props #(
  parameter int PIX_W = `PMR_PIX_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Inputs watched
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_in,
  input wire logic [`PMR_MODE_W-1:0] mode_in,
  input wire logic lut_valid,
  input wire logic [23:0] lut_rgb,
  // Outputs watched
  input wire logic out_valid_r,
  input wire logic out_is_rgb_r,
  input wire logic [PIX_W-1:0] pix_out_r,
  input wire logic video_valid_r,
  input wire logic [31:0] video_word_r
);
  logic [PIX_W-1:0] pd; // Pixel one edge back
  logic [`PMR_MODE_W-1:0] md; // Mode one edge back

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // No reset, so the copy is valid right after release
  always_ff @(posedge sys_clk) begin
    pd <= pix_in;
    md <= mode_in;
  end

  AST_VALID: assert property (pix_valid |=> out_valid_r)
    else $error("pixel valid not carried to output");
  AST_KIND: assert property (
    out_valid_r |-> out_is_rgb_r == (md[9:8] != 2'h0))
    else $error("rgb flag does not follow kind");
  AST_UPPER: assert property (
    out_valid_r && !out_is_rgb_r |-> pix_out_r[23:13] == 11'h000)
    else $error("index upper bits not zero");
  AST_IDX8: assert property (
    out_valid_r && md[9:8] == 2'h0 && md[11:10] == 2'h1
    |-> pix_out_r[12:0] == {md[7:3], pd[7:0]})
    else $error("eight bit index address wrong");
  AST_IDX4: assert property (
    out_valid_r && md[9:8] == 2'h0 && md[11:10] == 2'h0
    |-> pix_out_r[12:0] == {md[7:3], 4'h0, md[0] ? pd[7:4] : pd[3:0]})
    else $error("four bit index address wrong");
  AST_RGB24: assert property (
    out_valid_r && md[9:8] != 2'h0 && md[11:10] == 2'h3
    |-> pix_out_r[23:16] == {pd[2], pd[5], pd[8], pd[11], pd[14],
    pd[17], pd[20], pd[23]})
    else $error("blue de-interleave wrong");
  AST_RGB4: assert property (
    out_valid_r && md[9:8] != 2'h0 && md[11:10] == 2'h0
    |-> pix_out_r[15:8] == {4{md[0] ? {pd[4], pd[7]} : {pd[0], pd[3]}}})
    else $error("four bit green repeat wrong");
  AST_VIDEO: assert property (
    video_valid_r |-> $past(lut_valid) && video_word_r[23:0] == $past(lut_rgb))
    else $error("video word lost lookup rgb");
endmodule

bind pmr_top pmr_top_props #(.PIX_W(PIX_W)) i_pmr_top_props (.sys_clk,
  .reset_n, .pix_valid, .pix_in, .mode_in, .lut_valid, .lut_rgb,
  .out_valid_r, .out_is_rgb_r, .pix_out_r, .video_valid_r, .video_word_r);
`default_nettype wire

// ---- test/pmr_lut_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Lookup chip stand-in, one edge of its own delay
// ----------------------------------------------------------------
module pmr_lut_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Word from the reformatter
  input wire logic out_valid_r,
  input wire logic [23:0] pix_out_r,
  // Returning rgb
  output var logic lut_valid,
  output var logic [23:0] lut_rgb
);
  // Every word is looked up, none bypasses
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lut_valid <= 1'b0;
      lut_rgb <= 24'h5a_a5c3;
    end else begin
      lut_valid <= #1 out_valid_r;
      // Idle bus shows a changing pattern, not the last word
      lut_rgb <= #1 out_valid_r ? pix_out_r ^ 24'h5a_a53c : ~lut_rgb;
    end
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmr_defs.svh"

// ----------------------------------------------------------------
// Self-checking bench with reference model
// ----------------------------------------------------------------
module testbench;
  typedef struct {
    logic v, r, ap;
    logic [23:0] p;
    logic [9:0] pa;
    logic [7:0] al;
  } pmr_exp_t;
  logic sys_clk = 0, reset_n = 0, pix_valid = 0, alpha_en = 0;
  logic [23:0] pix_in = 0, lut_rgb, pix_out_r;
  logic [`PMR_MODE_W-1:0] mode_in = 0;
  logic [1:0] popup_in = 0, popup_out_r;
  logic [7:0] aux_in = 0, aux_out_r;
  logic lut_valid, out_valid_r, out_is_rgb_r, video_valid_r;
  logic [31:0] video_word_r, r1, r2;
  pmr_exp_t h [3]; // Expectations by age in edges
  int n_mismatch = 0, n_checks = 0, cyc = 0, t, t_b;

  pmr_top i_pmr_top (.sys_clk(sys_clk), .reset_n(reset_n),
    .pix_valid(pix_valid), .pix_in(pix_in), .mode_in(mode_in),
    .alpha_en(alpha_en), .popup_in(popup_in), .aux_in(aux_in),
    .lut_valid(lut_valid), .lut_rgb(lut_rgb), .out_valid_r(out_valid_r),
    .out_is_rgb_r(out_is_rgb_r), .pix_out_r(pix_out_r),
    .popup_out_r(popup_out_r), .aux_out_r(aux_out_r),
    .video_valid_r(video_valid_r), .video_word_r(video_word_r));
  pmr_lut_model i_pmr_lut_model (.sys_clk(sys_clk), .reset_n(reset_n),
    .out_valid_r(out_valid_r), .pix_out_r(pix_out_r),
    .lut_valid(lut_valid), .lut_rgb(lut_rgb));

  initial forever #50 sys_clk = ~sys_clk;

  // Buffer bit only counts in the double layouts
  function automatic int eff_buf(input logic [13:0] m, input logic a);
    int d;
    logic c;
    d = m[11:10];
    c = m[9:8] != 2'h0 && a;
    return m[0] && (d == 0 || (d == 1 && c) || (d == 2 && !c));
  endfunction

  // Expected word towards the lookup
  function automatic logic [23:0] exp_pix(input logic [13:0] m,
      input logic [23:0] p, input logic a);
    int d, n, o, b, c, j;
    logic [23:0] q;
    d = m[11:10];
    b = eff_buf(m, a);
    q = 24'h00_0000;
    if (m[9:8] == 2'h0) begin
      if (d == 0) q[12:0] = {m[7:3], 4'h0, b ? p[7:4] : p[3:0]};
      else if (d == 2) q[12:0] = {m[7], b ? p[23:12] : p[11:0]};
      else q[12:0] = {m[7:3], p[7:0]};
    end else begin
      o = b ? (d == 0 ? 4 : 12) : 0;
      // Channel c: 0 green, 1 red, 2 blue; sources repeat msb first
      for (c = 0; c < 3; c++) begin
        n = d == 3 ? 8 : d == 2 ? 4 : d == 1 ? (c == 2 ? 2 : 3) :
          (c == 0 ? 2 : 1);
        for (j = 0; j < 8; j++)
          q[(c == 2 ? 23 : c == 0 ? 15 : 7) - j] = p[o + c + 3 * (j % n)];
      end
    end
    return q;
  endfunction

  task automatic cmp(input string nm, input logic [31:0] e, s);
    n_checks++;
    if (e !== s) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Model takes what the design samples at each edge
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) h[i].v = 1'b0;
    end else begin
      h[2] = h[1];
      h[1] = h[0];
      h[0].v = pix_valid;
      h[0].r = mode_in[9:8] != 2'h0;
      h[0].p = exp_pix(mode_in, pix_in, alpha_en);
      h[0].pa = {popup_in, aux_in};
      h[0].ap = h[0].r && alpha_en && mode_in[11:10] inside {2'h1, 2'h2};
      t_b = eff_buf(mode_in, alpha_en) != 0 ? 20 : 8;
      for (int i = 0; i < 8; i++)
        h[0].al[i] = mode_in[11:10] == 2'h2 ? pix_in[19 - i] :
          i >= 4 ? pix_in[t_b + 7 - i] : 1'b0;
    end
  end

  // Outputs are settled by the falling edge
  always @(negedge sys_clk) begin
    if (reset_n) begin
      cmp("out_valid", h[0].v, out_valid_r);
      if (h[0].v) begin
        cmp("is_rgb", h[0].r, out_is_rgb_r);
        cmp("pix_out", h[0].p, pix_out_r);
        cmp("side", h[0].pa, {popup_out_r, aux_out_r});
      end
      cmp("video_valid", h[2].v & h[2].ap, video_valid_r);
      if (h[2].v && h[2].ap)
        cmp("video", {h[2].al, h[2].p ^ 24'h5a_a53c}, video_word_r);
    end
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      finish_test;
    end
  end

  initial begin
    void'($urandom(32'h920c));
    repeat (10) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    // Every kind and depth pair, both buffers drawn at random
    for (t = 0; t < 16; t++) begin
      repeat (40) begin
        @(posedge sys_clk);
        #1;
        r1 = $urandom;
        r2 = $urandom;
        pix_in = r1[23:0];
        mode_in = {r2[13:12], t[3:0], r2[7:0]};
        pix_valid = r2[31:30] != 2'h0;
        alpha_en = r2[29];
        {popup_in, aux_in} = r2[27:18];
        // Reset in mid-stream at random cycles while t is 8
        reset_n = !(t == 8 && r1[31:29] == 3'h0);
      end
      $display("test %0d done", t);
    end
    finish_test;
  end
endmodule
`default_nettype wire
